// [design/homing_pkg.sv]
// Constants and types shared by the homing sequencer files
// What this block does
// - Method select value picks one trajectory
// - Search and limit reversals run fast, return legs slow
// - M25 on switch: CCW slow, reverse, stop
// - M25 CW side: CW limit, reverse, stop
// - M26 CCW side: slow on switch, stop
// - M26/M27 on switch: CW slow, stop release
// - M26 CW side: limit, reverse, slow CW
// - M27 CCW side: CCW limit, reverse, release
// - M27 CW side: CCW fast, slow CW
// - M28 CCW side: limit, CW, CCW, reactivation
// - M28 on switch: CW, reverse, reactivation
// - M28 CW side: CCW fast, stop on switch
// - M29 CCW side: limit, reverse, stop switch
// - M29 on switch: CCW, reverse CW, reactivation
// - M29 CW side: pass switch, CW slow
// - M30 CCW side: limit, CW, CCW slow
// - M30 on switch: CCW slow, stop release
// - M30 CW side: CCW fast, then slow
// - Reserved methods produce no motion at all
// - M33: CCW, stop at first index pulse
// - M34: CW, stop at first index pulse
// - M35: current position becomes origin, no motion
package homing_pkg;

  // Port widths
  localparam int METHOD_W = 6;
  localparam int SPEED_W = 16;
  localparam int POS_W = 32;

  // Method select values handled here
  localparam logic [METHOD_W-1:0] M25 = 6'h19;
  localparam logic [METHOD_W-1:0] M26 = 6'h1A;
  localparam logic [METHOD_W-1:0] M27 = 6'h1B;
  localparam logic [METHOD_W-1:0] M28 = 6'h1C;
  localparam logic [METHOD_W-1:0] M29 = 6'h1D;
  localparam logic [METHOD_W-1:0] M30 = 6'h1E;
  localparam logic [METHOD_W-1:0] M31 = 6'h1F;
  localparam logic [METHOD_W-1:0] M32 = 6'h20;
  localparam logic [METHOD_W-1:0] M33 = 6'h21;
  localparam logic [METHOD_W-1:0] M34 = 6'h22;
  localparam logic [METHOD_W-1:0] M35 = 6'h23;

  // Bit positions in the synchronised input vector
  localparam int IN_HOME = 0;
  localparam int IN_CWL = 1;
  localparam int IN_CCWL = 2;
  localparam int IN_INDEX = 3;
  localparam int IN_STEP = 4;
  localparam int IN_DIR = 5;
  localparam int IN_W = 6;

  // Finishing plan: kind, direction and speed of first leg
  localparam logic [1:0] KIND_STOP = 2'h0;
  localparam logic [1:0] KIND_FALL = 2'h1;
  localparam logic [1:0] KIND_FALL_RISE = 2'h2;
  localparam logic DIR_CW = 1'b1;
  localparam logic DIR_CCW = 1'b0;
  localparam logic SPD_FAST = 1'b1;
  localparam logic SPD_SLOW = 1'b0;
  localparam int PLAN_SPD = 0;
  localparam int PLAN_DIR = 1;
  localparam int PLAN_KIND_LSB = 2;
  localparam int PLAN_KIND_MSB = 3;

  localparam logic [3:0] PLAN_STOP = {KIND_STOP, DIR_CCW, SPD_SLOW};
  localparam logic [3:0] PLAN_F_CW_S = {KIND_FALL, DIR_CW, SPD_SLOW};
  localparam logic [3:0] PLAN_F_CCW_S = {KIND_FALL, DIR_CCW, SPD_SLOW};
  localparam logic [3:0] PLAN_FR_CW_S = {KIND_FALL_RISE, DIR_CW, SPD_SLOW};
  localparam logic [3:0] PLAN_FR_CCW_S =
    {KIND_FALL_RISE, DIR_CCW, SPD_SLOW};
  localparam logic [3:0] PLAN_FR_CW_F = {KIND_FALL_RISE, DIR_CW, SPD_FAST};
  localparam logic [3:0] PLAN_FR_CCW_F =
    {KIND_FALL_RISE, DIR_CCW, SPD_FAST};

  // Reset and step values
  localparam logic [POS_W-1:0] POS_ZERO = 32'h0000_0000;
  localparam logic [POS_W-1:0] POS_ONE = 32'h0000_0001;
  localparam logic [SPEED_W-1:0] SPEED_ZERO = 16'h0000;

  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SEARCH = 3'h1,
    S_REVERSE = 3'h2,
    S_LEG1 = 3'h3,
    S_LEG2 = 3'h4,
    S_INDEX = 3'h5,
    S_DONE = 3'h6,
    S_FAULT = 3'h7
  } state_t;

endpackage : homing_pkg

// [design/homing_sequencer.sv]
// Homing sequencer: methods 25 to 35 of the servo drive
`timescale 1ns/10ps
module homing_sequencer
  import homing_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic home_request_in,
  input wire logic [METHOD_W-1:0] homing_method_select_in,
  input wire logic [SPEED_W-1:0] homing_fast_speed_in,
  input wire logic [SPEED_W-1:0] homing_slow_speed_in,
  input wire logic home_switch_in,
  input wire logic cw_limit_in,
  input wire logic ccw_limit_in,
  input wire logic enc_index_in,
  input wire logic enc_step_in,
  input wire logic enc_dir_cw_in,
  output logic motion_enable_out,
  output logic dir_cw_out,
  output logic [SPEED_W-1:0] speed_cmd_out,
  output logic homing_busy_out,
  output logic homing_done_out,
  output logic homing_fault_out,
  output logic [POS_W-1:0] position_out
);

  // Plan when the move starts on the home switch
  function automatic logic [3:0] plan_on_switch(
    input logic [METHOD_W-1:0] m
  );
    case (m)
      M25: plan_on_switch = PLAN_FR_CCW_S;
      M26: plan_on_switch = PLAN_F_CW_S;
      M27: plan_on_switch = PLAN_F_CW_S;
      M28: plan_on_switch = PLAN_FR_CW_S;
      M29: plan_on_switch = PLAN_FR_CCW_S;
      M30: plan_on_switch = PLAN_F_CCW_S;
      default: plan_on_switch = PLAN_STOP;
    endcase
  endfunction : plan_on_switch

  // Plan when the fast search meets the switch head-on
  function automatic logic [3:0] plan_search_hit(
    input logic [METHOD_W-1:0] m
  );
    case (m)
      M25: plan_search_hit = PLAN_FR_CW_F;
      M26: plan_search_hit = PLAN_F_CW_S;
      M27: plan_search_hit = PLAN_F_CW_S;
      M28: plan_search_hit = PLAN_STOP;
      M29: plan_search_hit = PLAN_FR_CCW_F;
      M30: plan_search_hit = PLAN_F_CCW_S;
      default: plan_search_hit = PLAN_STOP;
    endcase
  endfunction : plan_search_hit

  // Plan when the switch is met after a limit reversal
  function automatic logic [3:0] plan_reverse_hit(
    input logic [METHOD_W-1:0] m
  );
    case (m)
      M25: plan_reverse_hit = PLAN_STOP;
      M26: plan_reverse_hit = PLAN_F_CW_S;
      M27: plan_reverse_hit = PLAN_F_CW_S;
      M28: plan_reverse_hit = PLAN_FR_CW_S;
      M29: plan_reverse_hit = PLAN_STOP;
      M30: plan_reverse_hit = PLAN_F_CCW_S;
      default: plan_reverse_hit = PLAN_STOP;
    endcase
  endfunction : plan_reverse_hit

  // Initial search direction of a switch method
  function automatic logic search_dir(
    input logic [METHOD_W-1:0] m
  );
    // Methods 25 and 26 look clockwise first
    search_dir = (m == M25 || m == M26) ? DIR_CW : DIR_CCW;
  endfunction : search_dir

  // Limit lying ahead in the direction of travel
  function automatic logic limit_ahead(
    input logic dir_cw,
    input logic cwl,
    input logic ccwl
  );
    limit_ahead = dir_cw ? cwl : ccwl;
  endfunction : limit_ahead

  // Synchronised pin levels and edges
  logic [IN_W-1:0] pin_raw;
  logic [IN_W-1:0] pin_lvl;
  logic [IN_W-1:0] pin_rise;
  logic [IN_W-1:0] pin_fall;

  // State and working registers
  state_t state_r;
  state_t state_nxt;
  logic [METHOD_W-1:0] method_r;
  logic [METHOD_W-1:0] method_nxt;
  logic dir_r;
  logic dir_nxt;
  logic fast_r;
  logic fast_nxt;
  // Whether the first leg is followed by a return leg
  logic two_leg_r;
  logic two_leg_nxt;
  logic finish;
  logic take_req;

  // Output registers
  logic motion_r;
  logic dir_cmd_r;
  logic [SPEED_W-1:0] speed_r;
  logic busy_r;
  logic done_r;
  logic fault_r;
  logic [POS_W-1:0] pos_r;

  // Decoded helpers
  wire sw_lvl = pin_lvl[IN_HOME];
  wire sw_rise = pin_rise[IN_HOME];
  wire sw_fall = pin_fall[IN_HOME];
  wire idx_rise = pin_rise[IN_INDEX];
  wire step_rise = pin_rise[IN_STEP];
  wire step_cw = pin_lvl[IN_DIR];
  wire lim_hit = limit_ahead(dir_r, pin_lvl[IN_CWL], pin_lvl[IN_CCWL]);
  wire state_idle = state_r == S_IDLE || state_r == S_DONE ||
    state_r == S_FAULT;
  wire sel_switch = homing_method_select_in >= M25 &&
    homing_method_select_in <= M30;
  wire sel_reserved = homing_method_select_in == M31 ||
    homing_method_select_in == M32;
  wire moving_nxt = state_nxt == S_SEARCH || state_nxt == S_REVERSE ||
    state_nxt == S_LEG1 || state_nxt == S_LEG2 ||
    state_nxt == S_INDEX;
  wire [3:0] on_plan = plan_on_switch(homing_method_select_in);
  wire [3:0] srch_plan = plan_search_hit(method_r);
  wire [3:0] rev_plan = plan_reverse_hit(method_r);
  // Plan chosen by the state in which the switch was met
  wire [3:0] hit_plan = (state_r == S_SEARCH) ? srch_plan : rev_plan;
  wire [1:0] hit_kind = hit_plan[PLAN_KIND_MSB:PLAN_KIND_LSB];
  wire [1:0] on_kind = on_plan[PLAN_KIND_MSB:PLAN_KIND_LSB];
  wire [SPEED_W-1:0] speed_sel =
    fast_nxt ? homing_fast_speed_in : homing_slow_speed_in;

  // Requests are only taken when no move is under way
  assign take_req = home_request_in && state_idle;

  // All switch, limit and encoder pins pass the two-stage synchroniser
  assign pin_raw[IN_HOME] = home_switch_in;
  assign pin_raw[IN_CWL] = cw_limit_in;
  assign pin_raw[IN_CCWL] = ccw_limit_in;
  assign pin_raw[IN_INDEX] = enc_index_in;
  assign pin_raw[IN_STEP] = enc_step_in;
  assign pin_raw[IN_DIR] = enc_dir_cw_in;

  pin_sync #(
    .W(IN_W)
  ) u_pin_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(pin_raw),
    .level_out(pin_lvl),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // Next-state logic of the trajectory engine
  always_comb
  begin
    state_nxt = state_r;
    method_nxt = method_r;
    dir_nxt = dir_r;
    fast_nxt = fast_r;
    two_leg_nxt = two_leg_r;
    finish = 1'b0;
    case (state_r)
      S_IDLE, S_DONE, S_FAULT:
      begin
        if (take_req)
        begin
          method_nxt = homing_method_select_in;
          if (sel_reserved)
          begin
            // Nothing moves, nothing is zeroed
            state_nxt = S_IDLE;
          end
          else if (homing_method_select_in == M35)
          begin
            // Origin taken where the axis stands
            finish = 1'b1;
            state_nxt = S_DONE;
          end
          else if (homing_method_select_in == M33)
          begin
            state_nxt = S_INDEX;
            dir_nxt = DIR_CCW;
            fast_nxt = SPD_SLOW;
          end
          else if (homing_method_select_in == M34)
          begin
            state_nxt = S_INDEX;
            dir_nxt = DIR_CW;
            fast_nxt = SPD_SLOW;
          end
          else if (sel_switch && sw_lvl)
          begin
            // Already on the switch: slow leg at once
            state_nxt = S_LEG1;
            dir_nxt = on_plan[PLAN_DIR];
            fast_nxt = on_plan[PLAN_SPD];
            two_leg_nxt = on_kind == KIND_FALL_RISE;
          end
          else if (sel_switch)
          begin
            state_nxt = S_SEARCH;
            dir_nxt = search_dir(homing_method_select_in);
            fast_nxt = SPD_FAST;
          end
          else
          begin
            // Methods outside this block stay idle
            state_nxt = S_IDLE;
          end
        end
      end
      S_SEARCH, S_REVERSE:
      begin
        if (sw_rise && hit_kind == KIND_STOP)
        begin
          finish = 1'b1;
          state_nxt = S_DONE;
        end
        else if (sw_rise)
        begin
          state_nxt = S_LEG1;
          dir_nxt = hit_plan[PLAN_DIR];
          fast_nxt = hit_plan[PLAN_SPD];
          two_leg_nxt = hit_kind == KIND_FALL_RISE;
        end
        else if (lim_hit && state_r == S_SEARCH)
        begin
          // Limit ahead turns the search around
          state_nxt = S_REVERSE;
          dir_nxt = ~dir_r;
          fast_nxt = SPD_FAST;
        end
        else if (lim_hit)
        begin
          // Second limit means no switch was found
          state_nxt = S_FAULT;
        end
      end
      S_LEG1:
      begin
        if (sw_fall && two_leg_r)
        begin
          // Back onto the switch slowly
          state_nxt = S_LEG2;
          dir_nxt = ~dir_r;
          fast_nxt = SPD_SLOW;
        end
        else if (sw_fall)
        begin
          finish = 1'b1;
          state_nxt = S_DONE;
        end
        else if (lim_hit)
        begin
          state_nxt = S_FAULT;
        end
      end
      S_LEG2:
      begin
        if (sw_rise)
        begin
          finish = 1'b1;
          state_nxt = S_DONE;
        end
        else if (lim_hit)
        begin
          state_nxt = S_FAULT;
        end
      end
      S_INDEX:
      begin
        if (idx_rise)
        begin
          // First index edge is the origin
          finish = 1'b1;
          state_nxt = S_DONE;
        end
        else if (lim_hit)
        begin
          state_nxt = S_FAULT;
        end
      end
      default:
      begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Trajectory state registers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_r <= S_IDLE;
      method_r <= '0;
      dir_r <= DIR_CCW;
      fast_r <= SPD_SLOW;
      two_leg_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      method_r <= method_nxt;
      dir_r <= dir_nxt;
      fast_r <= fast_nxt;
      two_leg_r <= two_leg_nxt;
    end
  end

  // Motion command registers, zero speed when stopped
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      motion_r <= 1'b0;
      dir_cmd_r <= DIR_CCW;
      speed_r <= SPEED_ZERO;
      busy_r <= 1'b0;
    end
    else
    begin
      motion_r <= moving_nxt;
      dir_cmd_r <= dir_nxt;
      speed_r <= moving_nxt ? speed_sel : SPEED_ZERO;
      busy_r <= moving_nxt;
    end
  end

  // Done held until the next request; fault likewise
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      done_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else
    begin
      // Finishing wins over the clear of the same cycle
      done_r <= finish | (done_r & ~take_req);
      fault_r <= (state_nxt == S_FAULT) & ~finish;
    end
  end

  // Position counter; the origin zero wins over a step
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pos_r <= POS_ZERO;
    end
    else if (finish)
    begin
      pos_r <= POS_ZERO;
    end
    else if (step_rise)
    begin
      pos_r <= step_cw ? pos_r + POS_ONE : pos_r - POS_ONE;
    end
  end

  // Outputs straight from flip-flops
  assign motion_enable_out = motion_r;
  assign dir_cw_out = dir_cmd_r;
  assign speed_cmd_out = speed_r;
  assign homing_busy_out = busy_r;
  assign homing_done_out = done_r;
  assign homing_fault_out = fault_r;
  assign position_out = pos_r;

endmodule : homing_sequencer

// [design/pin_sync.sv]
// Two-stage pin synchroniser with edge detection
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out,
  output logic [W-1:0] rise_out,
  output logic [W-1:0] fall_out
);

  // First stage, only the second stage reads it
  logic [W-1:0] meta_r;
  // Second stage, safe to use
  logic [W-1:0] sync_r;
  // Previous sync value for edges
  logic [W-1:0] prev_r;

  // Shift chain, cleared on reset
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Edges from the stable stages only
  assign level_out = sync_r;
  assign rise_out = sync_r & ~prev_r;
  assign fall_out = ~sync_r & prev_r;

endmodule : pin_sync

// [dv/homing_sequencer_asserts.sv]
// Port checker for the homing sequencer, bound to its top module
`timescale 1ns/10ps
module homing_sequencer_asserts
  import homing_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic home_request_in,
  input wire logic [METHOD_W-1:0] homing_method_select_in,
  input wire logic [SPEED_W-1:0] homing_fast_speed_in,
  input wire logic [SPEED_W-1:0] homing_slow_speed_in,
  input wire logic motion_enable_out,
  input wire logic dir_cw_out,
  input wire logic [SPEED_W-1:0] speed_cmd_out,
  input wire logic homing_done_out,
  input wire logic homing_fault_out,
  input wire logic [POS_W-1:0] position_out
);
  // Single clock domain, reset disables every check
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // A request the sequencer takes: it is not moving
  sequence take_s(logic [METHOD_W-1:0] m);
    home_request_in && !motion_enable_out && homing_method_select_in == m;
  endsequence

  a_speed_is_param: assert property (motion_enable_out |->
    (speed_cmd_out == homing_fast_speed_in ||
     speed_cmd_out == homing_slow_speed_in))
    else $error("speed is neither homing speed");
  a_still_no_speed: assert property (!motion_enable_out |->
    speed_cmd_out == SPEED_ZERO)
    else $error("speed while stopped");
  a_done_zero_pos: assert property ($rose(homing_done_out) |->
    position_out == POS_ZERO)
    else $error("origin not zeroed");
  a_done_holds: assert property (homing_done_out && !home_request_in
    |=> homing_done_out)
    else $error("done dropped without request");
  a_stop_gives_done: assert property ($fell(motion_enable_out) &&
    !homing_fault_out |-> homing_done_out)
    else $error("stop without done");
  a_reserved_none: assert property ((take_s(M31) or take_s(M32))
    |=> !motion_enable_out && !homing_done_out)
    else $error("reserved method acted");
  a_origin_now: assert property (take_s(M35) |=> homing_done_out &&
    !motion_enable_out && position_out == POS_ZERO)
    else $error("present point not origin");
  a_cw_index_go: assert property (take_s(M34) |=>
    motion_enable_out && dir_cw_out)
    else $error("index search not clockwise");
  a_ccw_index_go: assert property (take_s(M33) |=>
    motion_enable_out && !dir_cw_out)
    else $error("index search not counter-clockwise");
endmodule : homing_sequencer_asserts

bind homing_sequencer homing_sequencer_asserts u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .home_request_in(home_request_in),
  .homing_method_select_in(homing_method_select_in),
  .homing_fast_speed_in(homing_fast_speed_in),
  .homing_slow_speed_in(homing_slow_speed_in),
  .motion_enable_out(motion_enable_out), .dir_cw_out(dir_cw_out),
  .speed_cmd_out(speed_cmd_out), .homing_done_out(homing_done_out),
  .homing_fault_out(homing_fault_out), .position_out(position_out)
);

// [dv/motor_model.sv]
// Behavioural axis: motor, limit and home switches, encoder
`timescale 1ns/10ps
module motor_model (
  input wire logic clk_in,
  input wire logic load_in,
  input wire logic [15:0] load_pos_in,
  input wire logic motion_enable_in,
  input wire logic dir_cw_in,
  output logic home_switch_out,
  output logic cw_limit_out,
  output logic ccw_limit_out,
  output logic enc_index_out,
  output logic enc_step_out,
  output logic enc_dir_cw_out,
  output logic [15:0] pos_out
);
  logic signed [15:0] pos_r = 16'sh0014; // Shaft position, signed units
  logic [2:0] tick_r = 3'h0; // Eight cycles per step, beats pin lag
  initial enc_step_out = 1'b0;
  initial enc_dir_cw_out = 1'b0;

  // Move one unit per eight enabled cycles; load teleports silently
  always @(posedge clk_in)
  begin
    enc_step_out <= 1'b0;
    if (load_in)
    begin
      pos_r <= $signed(load_pos_in);
      tick_r <= 3'h0;
    end
    else if (motion_enable_in)
    begin
      tick_r <= tick_r + 3'h1;
      if (tick_r == 3'h7)
      begin
        pos_r <= dir_cw_in ? pos_r + 16'sh0001 : pos_r - 16'sh0001;
        enc_step_out <= 1'b1; // One count pulse per unit
        enc_dir_cw_out <= dir_cw_in;
      end
    end
    else
      tick_r <= 3'h0; // Stopped: restart the step phase
  end

  // Switch band 40..47, limits at 0 and 100, index every 16 units
  assign home_switch_out = pos_r >= 16'sh0028 && pos_r <= 16'sh002F;
  assign cw_limit_out = pos_r >= 16'sh0064;
  assign ccw_limit_out = pos_r <= 16'sh0000;
  assign enc_index_out = pos_r[3:0] == 4'h0;
  assign pos_out = pos_r;
endmodule : motor_model

// [dv/tb.sv]
// Self-checking bench running every homing method on a model axis
`timescale 1ns/10ps
module tb
  import homing_pkg::*;
;
  localparam logic [15:0] FAST = 16'h0300; // Search speed
  localparam logic [15:0] SLOW = 16'h0050; // Approach speed
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic req = 1'b0;
  logic load = 1'b0;
  logic [METHOD_W-1:0] method = 6'h00;
  logic [15:0] load_pos = 16'h0014;
  wire sw, cwl, ccwl, idx, stp, sdir, motion, dcw, busy, done, fault;
  wire [15:0] spd, mpos;
  wire [31:0] pos;
  int miscompares = 0;
  int total_checks = 0;

  // Free-running 40 MHz clock
  always #12.5 clk_in = ~clk_in;

  homing_sequencer dut (.clk_in(clk_in), .rst_in(rst_in),
    .home_request_in(req), .homing_method_select_in(method),
    .homing_fast_speed_in(FAST), .homing_slow_speed_in(SLOW),
    .home_switch_in(sw), .cw_limit_in(cwl), .ccw_limit_in(ccwl),
    .enc_index_in(idx), .enc_step_in(stp), .enc_dir_cw_in(sdir),
    .motion_enable_out(motion), .dir_cw_out(dcw), .speed_cmd_out(spd),
    .homing_busy_out(busy), .homing_done_out(done),
    .homing_fault_out(fault), .position_out(pos));

  motor_model u_axis (.clk_in(clk_in), .load_in(load),
    .load_pos_in(load_pos), .motion_enable_in(motion), .dir_cw_in(dcw),
    .home_switch_out(sw), .cw_limit_out(cwl), .ccw_limit_out(ccwl),
    .enc_index_out(idx), .enc_step_out(stp), .enc_dir_cw_out(sdir),
    .pos_out(mpos));

  // Compare helpers, one per result width
  task automatic chk_bit(input logic g, input logic e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t flag got %b want %b", $time, g, e);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t word got %h want %h", $time, g, e);
    end
  endtask : chk_word

  task automatic chk_pos(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t position got %h want %h", $time, g, e);
    end
  endtask : chk_pos

  // Place axis, request method, judge first leg and stop point
  // mv: 0 no motion, 1 slow first leg, 2 fast first leg
  task automatic run_case(input logic [5:0] m, input logic [15:0] st,
    input logic [15:0] sp, input logic d, input logic [1:0] mv,
    input logic dn);
    int i;
    @(negedge clk_in);
    load = 1'b1;
    load_pos = st;
    @(negedge clk_in);
    load = 1'b0;
    repeat (4) @(negedge clk_in); // Let pin synchronisers settle
    method = m;
    req = 1'b1;
    @(negedge clk_in);
    req = 1'b0;
    chk_bit(motion, mv != 2'h0);
    if (mv != 2'h0)
    begin
      chk_bit(dcw, d);
      chk_word(spd, (mv == 2'h2) ? FAST : SLOW);
      repeat (14) @(negedge clk_in); // One step made and counted
      chk_pos(pos, d ? POS_ONE : POS_ZERO - POS_ONE);
    end
    for (i = 0; i < 4000 && busy !== 1'b0; i++)
      @(negedge clk_in);
    repeat (5) @(negedge clk_in); // Done must still stand
    chk_bit(busy, 1'b0);
    chk_bit(done, dn);
    chk_bit(fault, 1'b0);
    chk_pos(pos, POS_ZERO);
    chk_word(mpos, sp);
  endtask : run_case

  // Print counts and verdict, end the run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // Watchdog: well above the longest expected run
  initial
  begin
    #(40000 * 25);
    miscompares++;
    wrap_up();
  end

  // Axis: switch 40..47, start points 20, 44 (on switch), 70
  initial
  begin
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    run_case(M25, 16'h0014, 16'h002F, 1'b1, 2'h2, 1'b1);
    run_case(M25, 16'h002C, 16'h0028, 1'b0, 2'h1, 1'b1);
    run_case(M25, 16'h0046, 16'h002F, 1'b1, 2'h2, 1'b1);
    run_case(M26, 16'h0014, 16'h0030, 1'b1, 2'h2, 1'b1);
    run_case(M26, 16'h002C, 16'h0030, 1'b1, 2'h1, 1'b1);
    run_case(M26, 16'h0046, 16'h0030, 1'b1, 2'h2, 1'b1);
    run_case(M27, 16'h0014, 16'h0030, 1'b0, 2'h2, 1'b1);
    run_case(M27, 16'h002C, 16'h0030, 1'b1, 2'h1, 1'b1);
    run_case(M27, 16'h0046, 16'h0030, 1'b0, 2'h2, 1'b1);
    run_case(M28, 16'h0014, 16'h002F, 1'b0, 2'h2, 1'b1);
    run_case(M28, 16'h002C, 16'h002F, 1'b1, 2'h1, 1'b1);
    run_case(M28, 16'h0046, 16'h002F, 1'b0, 2'h2, 1'b1);
    run_case(M29, 16'h0014, 16'h0028, 1'b0, 2'h2, 1'b1);
    run_case(M29, 16'h002C, 16'h0028, 1'b0, 2'h1, 1'b1);
    run_case(M29, 16'h0046, 16'h0028, 1'b0, 2'h2, 1'b1);
    run_case(M30, 16'h0014, 16'h0027, 1'b0, 2'h2, 1'b1);
    run_case(M30, 16'h002C, 16'h0027, 1'b0, 2'h1, 1'b1);
    run_case(M30, 16'h0046, 16'h0027, 1'b0, 2'h2, 1'b1);
    run_case(M33, 16'h0014, 16'h0010, 1'b0, 2'h1, 1'b1);
    run_case(M34, 16'h0014, 16'h0020, 1'b1, 2'h1, 1'b1);
    run_case(M35, 16'h0014, 16'h0014, 1'b0, 2'h0, 1'b1);
    run_case(6'h18, 16'h0014, 16'h0014, 1'b0, 2'h0, 1'b0);
    run_case(M31, 16'h0014, 16'h0014, 1'b0, 2'h0, 1'b0);
    run_case(M32, 16'h002C, 16'h002C, 1'b0, 2'h0, 1'b0);
    wrap_up();
  end
endmodule : tb
